// >>> rtl/psr_pkg.sv
// package for the parallel-to-serial shift register: register map, field positions,
// reset values and pin bundle type.
// assumes a classic wishbone master with byte addresses on a 32-bit data bus.
package psr_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int PSR_STAGES = 8;
   localparam int PSR_ADR_W = 4;
   localparam int PSR_DAT_W = 32;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [PSR_ADR_W-1:0] PSR_REG_CTRL = 4'h0;
   localparam logic [PSR_ADR_W-1:0] PSR_REG_PDATA = 4'h4;
   localparam logic [PSR_ADR_W-1:0] PSR_REG_STAT = 4'h8;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int PSR_CTRL_STEP = 0;
   localparam int PSR_CTRL_LOADSEL_N = 1;
   localparam int PSR_CTRL_SERIAL = 2;
   localparam int PSR_CTRL_PIN_EN = 3;
   localparam int PSR_CTRL_W = 4;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [PSR_CTRL_W-1:0] PSR_CTRL_RST = 4'h8;
   localparam logic [PSR_STAGES-1:0] PSR_PDATA_RST = 8'h00;
   localparam logic [PSR_STAGES-1:0] PSR_STAGE_RST = 8'h00;

   // ------------------------------------------------------------
   // pin bundle from the controlling logic
   // ------------------------------------------------------------
   typedef struct packed {
      logic masterClearN;
      logic loadSelectN;
      logic clockGateN;
      logic shiftClock;
      logic serialIn;
      logic [PSR_STAGES-1:0] parallelIn;
   } psr_pins_t;

   localparam int PSR_PINS_W = $bits(psr_pins_t);

endpackage

// >>> rtl/psr_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels.
// assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/100ps
module psr_sync
   import psr_pkg::*;
#(
   parameter int W = 1
) (
   // clock and control
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clkEn,
   // levels
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } psr_sync_t;

   psr_sync_t st_r;
   psr_sync_t st_nxt;

   initial begin
      if (W < 1) $error("psr_sync: width must be positive");
   end

   always_comb begin
      st_nxt = st_r;
      if (clkEn) begin
         st_nxt.meta = asyncIn;
         st_nxt.stable = st_r.meta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign syncOut = st_r.stable;

endmodule

// >>> rtl/psr_top.sv
// eight-stage parallel-in serial-out shift register with a wishbone register port.
// assumes the pin bundle is asynchronous to ref_clk and the wishbone master runs on ref_clk.
`timescale 1ns/100ps
module psr_top
   import psr_pkg::*;
#(
   parameter int NSTAGES = PSR_STAGES
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clkEn,
   // pins from the controlling logic and the serial output
   input wire psr_pins_t pins,
   output logic serialOut,
   // wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [PSR_ADR_W-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [PSR_DAT_W-1:0] wbDatI,
   output logic [PSR_DAT_W-1:0] wbDatO,
   output logic wbAck
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NSTAGES-1:0] stage;
      logic serialOut;
      logic effClkPrev;
      logic [PSR_CTRL_W-1:0] ctrl;
      logic [NSTAGES-1:0] pdata;
      logic ack;
      logic [PSR_DAT_W-1:0] datO;
   } psr_state_t;

   psr_state_t st_r;
   psr_state_t st_nxt;
   psr_pins_t pinsSync;

   initial begin
      if (NSTAGES != PSR_STAGES) $error("psr_top: stage count must match the pin bundle");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   psr_sync #(
      .W(PSR_PINS_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .clkEn(clkEn),
      .asyncIn(pins),
      .syncOut(pinsSync)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one clocked step: load when select is low, else shift toward the last stage
   function automatic logic [NSTAGES-1:0] stepStages(
      input logic [NSTAGES-1:0] cur,
      input logic loadSelN,
      input logic sin,
      input logic [NSTAGES-1:0] par
   );
      logic [NSTAGES-1:0] res;
      if (!loadSelN) begin
         res = par;
      end else begin
         res = {cur[NSTAGES-2:0], sin};
      end
      return res;
   endfunction

   function automatic logic regHit(
      input logic [PSR_ADR_W-1:0] adr,
      input logic [PSR_ADR_W-1:0] off
   );
      return adr == off;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic effClk;
   logic pinEdge;
   logic wbReq;
   logic swStep;

   always_comb begin
      st_nxt = st_r;
      effClk = pinsSync.shiftClock | pinsSync.clockGateN;
      pinEdge = effClk & ~st_r.effClkPrev & st_r.ctrl[PSR_CTRL_PIN_EN];
      wbReq = wbCyc & wbStb & ~st_r.ack;
      swStep = 1'b0;
      if (clkEn) begin
         st_nxt.effClkPrev = effClk;
         st_nxt.ack = wbReq;
         st_nxt.datO = '0;
         st_nxt.ctrl[PSR_CTRL_STEP] = 1'b0;
         if (wbReq) begin
            if (regHit(wbAdr, PSR_REG_CTRL)) begin
               if (wbWe && wbSel[0]) begin
                  st_nxt.ctrl = wbDatI[PSR_CTRL_W-1:0];
                  // the step bit is a strobe and never stays set
                  st_nxt.ctrl[PSR_CTRL_STEP] = 1'b0;
                  swStep = wbDatI[PSR_CTRL_STEP];
               end
               st_nxt.datO[PSR_CTRL_W-1:0] = st_r.ctrl;
            end else if (regHit(wbAdr, PSR_REG_PDATA)) begin
               if (wbWe && wbSel[0]) begin
                  st_nxt.pdata = wbDatI[NSTAGES-1:0];
               end
               st_nxt.datO[NSTAGES-1:0] = st_r.pdata;
            end else if (regHit(wbAdr, PSR_REG_STAT)) begin
               st_nxt.datO[NSTAGES-1:0] = st_r.stage;
            end
            if (wbWe) begin
               st_nxt.datO = '0;
            end
         end
         if (!pinsSync.masterClearN) begin
            st_nxt.stage = PSR_STAGE_RST;
         end else if (pinEdge) begin
            st_nxt.stage = stepStages(st_r.stage, pinsSync.loadSelectN, pinsSync.serialIn,
                                      pinsSync.parallelIn);
         end else if (swStep) begin
            st_nxt.stage = stepStages(st_r.stage, wbDatI[PSR_CTRL_LOADSEL_N],
                                      wbDatI[PSR_CTRL_SERIAL], st_r.pdata);
         end
         st_nxt.serialOut = st_nxt.stage[NSTAGES-1];
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r.stage <= PSR_STAGE_RST;
         st_r.serialOut <= 1'b0;
         st_r.effClkPrev <= 1'b1;
         st_r.ctrl <= PSR_CTRL_RST;
         st_r.pdata <= PSR_PDATA_RST;
         st_r.ack <= 1'b0;
         st_r.datO <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign serialOut = st_r.serialOut;
   assign wbDatO = st_r.datO;
   assign wbAck = st_r.ack;

endmodule

// >>> test/psr_top_assertions.sv
// checker: bus handshake, clear, hold and freeze at the psr_top ports
// assumes it is bound to psr_top
`timescale 1ns/100ps
module psr_top_assertions
   import psr_pkg::*;
(
   // watched ports
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire psr_pins_t pins,
   input wire logic serialOut,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic [PSR_DAT_W-1:0] wbDatO,
   input wire logic wbAck
);
   // ----
   // relations
   // ----
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence s_req; wbCyc && wbStb && !wbAck && clkEn; endsequence
   sequence s_clr; (!pins.masterClearN && clkEn) [*3]; endsequence
   sequence s_hold; (pins.clockGateN && pins.masterClearN && !wbCyc && clkEn) [*4]; endsequence
   property p_ans; s_req |=> wbAck; endproperty
   a_ans: assert property (p_ans) else $error("ack late");
   property p_pulse; wbAck && clkEn |=> !wbAck; endproperty
   a_pulse: assert property (p_pulse) else $error("ack long");
   property p_quiet; !(wbCyc && wbStb) && clkEn |=> !wbAck; endproperty
   a_quiet: assert property (p_quiet) else $error("stray ack");
   property p_inCyc; wbAck |-> wbCyc; endproperty
   a_inCyc: assert property (p_inCyc) else $error("ack outside cycle");
   property p_idle; !wbAck |-> wbDatO == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("data outside ack");
   property p_clr; s_clr |=> !serialOut; endproperty
   a_clr: assert property (p_clr) else $error("clear late");
   property p_hold; s_hold |=> $stable(serialOut); endproperty
   a_hold: assert property (p_hold) else $error("moved while gated");
   property p_frz; !clkEn |=> $stable(serialOut) && $stable(wbAck); endproperty
   a_frz: assert property (p_frz) else $error("moved while frozen");
endmodule
bind psr_top psr_top_assertions psr_top_assertions_inst (.ref_clk, .srst, .clkEn, .pins, .serialOut, .wbCyc,
   .wbStb, .wbDatO, .wbAck);

// >>> test/psr_pins_model.sv
// controlling logic: drives the pin bundle
// assumes pin changes land on ref_clk edges, at least 3 cycles apart
`timescale 1ns/100ps
module psr_pins_model
   import psr_pkg::*;
(
   // clock and pins
   input wire logic ref_clk,
   output psr_pins_t pins
);
   // ----
   // pin tasks
   // ----
   initial pins = {5'b11000, 8'h00};
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic step(input logic ldN, input logic sIn, input logic [7:0] par, input logic gOn);
      wt(1);
      {pins.loadSelectN, pins.serialIn, pins.parallelIn} <= {ldN, sIn, par};
      wt(3);
      pins.shiftClock <= 1'b1;
      wt(3);
      pins.clockGateN <= gOn;
      wt(3);
      pins.shiftClock <= 1'b0;
      wt(3);
   endtask
   // roles swapped: the gate pin clocks while the clock pin stays low
   task automatic swap(input logic ldN, input logic sIn, input logic [7:0] par);
      wt(1);
      {pins.loadSelectN, pins.serialIn, pins.parallelIn} <= {ldN, sIn, par};
      wt(3);
      pins.clockGateN <= 1'b1;
      wt(3);
      pins.clockGateN <= 1'b0;
      wt(3);
   endtask
   task automatic clear();
      wt(1);
      pins.masterClearN <= 1'b0;
      wt(4);
      pins.masterClearN <= 1'b1;
      wt(3);
   endtask
endmodule

// >>> test/parallel_to_serial_shift_register_bench.sv
// bench: pin load, shift, gate, clear and register steps
// assumes psr_pins_model drives the pins; this module masters the bus
`timescale 1ns/100ps
module parallel_to_serial_shift_register_bench
   import psr_pkg::*;
;
   logic ref_clk, srst, clkEn, serialOut, wbCyc, wbStb, wbWe, wbAck, s;
   logic [3:0] wbAdr;
   logic [3:0] wbSel = 4'hf;
   logic [3:0] sel = 4'hf;
   logic [31:0] wbDatI, wbDatO;
   logic [7:0] st, w;
   psr_pins_t pins;
   logic [31:0] expQ[$];
   int numErrors = 0, testsRun = 0, seed = 32'hab4ac1b9;
   psr_top psr_top_inst (.ref_clk, .srst, .clkEn, .pins, .serialOut, .wbCyc, .wbStb, .wbWe, .wbAdr,
      .wbSel, .wbDatI, .wbDatO, .wbAck);
   psr_pins_model psr_pins_model_inst (.ref_clk, .pins);
   // ----
   // tasks
   // ----
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         numErrors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic completeRun();
      if (numErrors == 0 && testsRun > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI} <= {2'b11, we, sel, a, d};
      do @(posedge ref_clk); while (wbAck !== 1'b1);
      {wbCyc, wbStb} <= 2'b00;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic pin(input logic ldN, input logic g);
      psr_pins_model_inst.step(ldN, s, w, g);
   endtask
   always @(posedge ref_clk)
      if (wbAck === 1'b1 && !wbWe) check(wbDatO, expQ.pop_front());
   initial begin
      repeat (5000) @(posedge ref_clk);
      numErrors++;
      completeRun();
   end
   // ----
   // scenarios
   // ----
   initial begin
      {srst, clkEn, wbCyc, wbStb, wbWe, wbAdr, wbDatI} = {5'b11000, 4'h0, 32'h0};
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rd(PSR_REG_CTRL, 32'(PSR_CTRL_RST));
      {w, s} = 9'($random(seed));
      pin(1'b0, 1'b0);
      st = w;
      rd(PSR_REG_STAT, 32'(st));
      for (int i = 0; i < 8; i++) begin
         {w, s} = 9'($random(seed));
         pin(1'b1, 1'b0);
         st = {st[6:0], s};
         check(32'(serialOut), 32'(st[7]));
      end
      {w, s} = 9'($random(seed));
      psr_pins_model_inst.swap(1'b1, s, w);
      st = {st[6:0], s};
      check(32'(serialOut), 32'(st[7]));
      rd(PSR_REG_STAT, 32'(st));
      s = serialOut;
      pin(1'b1, 1'b0);
      st = {st[6:0], st[7]};
      check(32'(serialOut), 32'(st[7]));
      pin(1'b0, 1'b1);
      st = w;
      w = ~w;
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
      rd(PSR_REG_STAT, 32'(st));
      clkEn <= 1'b0;
      repeat (4) @(posedge ref_clk);
      clkEn <= 1'b1;
      psr_pins_model_inst.clear();
      rd(PSR_REG_STAT, 32'h0);
      check(32'(serialOut), 32'h0);
      bus(1'b1, PSR_REG_PDATA, 32'(w));
      bus(1'b1, PSR_REG_CTRL, 32'h9);
      rd(PSR_REG_STAT, 32'(w));
      bus(1'b1, PSR_REG_CTRL, 32'h7);
      st = {w[6:0], 1'b1};
      w = ~w;
      pin(1'b0, 1'b0);
      rd(PSR_REG_STAT, 32'(st));
      rd(PSR_REG_CTRL, 32'h6);
      sel = 4'he;
      bus(1'b1, PSR_REG_PDATA, 32'(w));
      sel = 4'hf;
      rd(PSR_REG_PDATA, {24'h0, ~w});
      bus(1'b1, 4'hc, 32'hffffffff);
      rd(4'hc, 32'h0);
      completeRun();
   end
endmodule
